// ### common/psrc_pkg.sv
// Shared constants and types for the loop status and reference oscillator trim block
package psrc_pkg;

  // Register offsets on the device register port
  localparam logic [7:0] PSRC_ADDR_CTRL   = 8'h91;
  localparam logic [7:0] PSRC_ADDR_STATUS = 8'h95;
  localparam logic [7:0] PSRC_ADDR_CAL    = 8'h98;

  // Field positions in the loop control register
  localparam int PSRC_MODE_MSB = 7;
  localparam int PSRC_MODE_LSB = 6;

  // Field positions in the status register
  localparam int PSRC_STAT_MCLK   = 0;
  localparam int PSRC_STAT_LOCK   = 3;
  localparam int PSRC_STAT_ACTIVE = 4;
  localparam int PSRC_STAT_TRACK  = 7;

  // Field positions in the oscillator calibration register
  localparam int PSRC_CAL_EN    = 7;
  localparam int PSRC_CAL_START = 6;
  localparam int PSRC_TRIM_MSB  = 4;
  localparam int PSRC_TRIM_W    = 5;

  // Values after reset
  localparam logic [7:0]             PSRC_STATUS_RST = 8'h00;
  localparam logic                   PSRC_CAL_EN_RST = 1'b0;
  localparam logic [PSRC_TRIM_W-1:0] PSRC_TRIM_RST   = 5'h00;
  localparam logic [7:0]             PSRC_RDATA_RST  = 8'h00;

  // Synchroniser depth and width for the single-bit analog inputs
  localparam int PSRC_SYNC_STAGES = 2;
  localparam int PSRC_SYNC_W      = 5;

  // Loop mode codes
  typedef enum logic [1:0] {
    PSRC_MODE_BYPASS = 2'h0,
    PSRC_MODE_NORMAL = 2'h1,
    PSRC_MODE_TRACK  = 2'h2,
    PSRC_MODE_RSVD   = 2'h3
  } psrc_mode_e;

  localparam psrc_mode_e PSRC_MODE_RST = PSRC_MODE_BYPASS;

  // Calibration handshake states, one-hot
  typedef enum logic [2:0] {
    PSRC_CAL_IDLE    = 3'h1,
    PSRC_CAL_RUN     = 3'h2,
    PSRC_CAL_RELEASE = 3'h4
  } psrc_cal_e;

  // Register port request
  typedef struct packed {
    logic       wrEn;
    logic       rdEn;
    logic [7:0] addr;
    logic [7:0] wrData;
  } psrc_regreq_s;

  // Inputs from the analog clock circuits
  typedef struct packed {
    logic                   mclkValid;
    logic                   pllLock;
    logic                   trackLock;
    logic                   standby;
    logic                   calAck;
    logic [PSRC_TRIM_W-1:0] calTrim;
  } psrc_ana_s;

endpackage

// ### dv/psrc_top_tb_top.sv
// Self-checking bench for loop status, mode control and oscillator trim calibration
`timescale 1ns/1ps

module psrc_top_tb_top;
  import psrc_pkg::*;

  logic         clk_sys;
  logic         rst;
  psrc_regreq_s regReq;
  psrc_ana_s    ana;
  logic [7:0]   rdDataQ;
  psrc_mode_e   loopModeQ;
  logic         refOscRunQ;
  logic         calReqQ;
  logic [7:0]   expQ[$];
  logic [7:0]   expV;
  logic         rdPend;
  logic [1:0]   md;
  logic [4:0]   trim;
  int           num_errors;
  int           checked;

  `define CHK(got, want) begin checked++; if ((got) !== (want)) begin num_errors++; \
    $display("ERROR t=%0t got=%0h exp=%0h", $time, got, want); end end

  psrc_top psrc_top_i (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .regReq     (regReq),
    .ana        (ana),
    .rdDataQ    (rdDataQ),
    .loopModeQ  (loopModeQ),
    .refOscRunQ (refOscRunQ),
    .calReqQ    (calReqQ)
  );

  // Free-running system clock
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // Read data lands one edge after the strobe, so the note is taken one edge later
  always @(posedge clk_sys) begin
    if (rdPend) begin
      expV = expQ.pop_front();
      `CHK(rdDataQ, expV)
    end
    rdPend <= regReq.rdEn & ~rst;
  end

  // One write: strobe for a single cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys); #1;
    regReq = '{wrEn: 1'b1, rdEn: 1'b0, addr: a, wrData: d};
    @(posedge clk_sys); #1;
    regReq.wrEn = 1'b0;
  endtask

  // One read, with its expected value noted for the monitor
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys); #1;
    regReq = '{wrEn: 1'b0, rdEn: 1'b1, addr: a, wrData: 8'h00};
    expQ.push_back(e);
    @(posedge clk_sys); #1;
    regReq.rdEn = 1'b0;
  endtask

  // Bounded wait on the tuner request; a hang ends the run
  task automatic waitReq(input logic v);
    int k;
    k = 0;
    while (calReqQ !== v && k < 50) begin
      @(posedge clk_sys); #1;
      k++;
    end
    `CHK(calReqQ, v)
    if (k >= 50) summarize();
  endtask

  // Status image for a given mode and set of analog levels
  function automatic logic [7:0] stat(input logic [1:0] m, input psrc_ana_s a);
    return {a.trackLock & (m == 2'h2), 2'b00, a.mclkValid & ~a.standby & (m != 2'h0),
            a.pllLock & (m != 2'h0), 2'b00, a.mclkValid};
  endfunction

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Main sequence
  initial begin
    regReq = '0;
    ana = '0;
    rst = 1'b1;
    rdPend = 1'b0;
    num_errors = 0;
    checked = 0;
    void'($urandom(4406));
    repeat (4) @(posedge clk_sys);
    #1 rst = 1'b0;
    rd(PSRC_ADDR_STATUS, PSRC_STATUS_RST);
    rd(PSRC_ADDR_CAL, 8'h00);
    rd(PSRC_ADDR_CTRL, 8'h00);
    $display("Test reset values done");
    // Every mode, a reserved-code write and a status write, under random levels
    for (int i = 0; i < 15; i++) begin
      md = 2'(i % 3);
      ana = psrc_ana_s'(10'($urandom));
      ana.calAck = 1'b0;
      wr(PSRC_ADDR_CTRL, {md, 6'($urandom)});
      wr(PSRC_ADDR_CTRL, {2'h3, 6'($urandom)});
      wr(PSRC_ADDR_STATUS, 8'($urandom));
      wr(PSRC_ADDR_CAL, {1'(i), 7'h00});
      repeat (4) @(posedge clk_sys);
      rd(PSRC_ADDR_CTRL, {md, 6'h00});
      `CHK(loopModeQ, psrc_mode_e'(md))
      rd(PSRC_ADDR_STATUS, stat(md, ana));
      `CHK(refOscRunQ, ~ana.mclkValid & ~ana.standby)
    end
    $display("Test modes and status done");
    // Start without enable is ignored, then a full run with enable
    wr(PSRC_ADDR_CAL, 8'h40);
    repeat (4) @(posedge clk_sys);
    `CHK(calReqQ, 1'b0)
    wr(PSRC_ADDR_CAL, 8'hC0);
    waitReq(1'b1);
    trim = 5'($urandom);
    ana.calTrim = trim;
    ana.calAck = 1'b1;
    waitReq(1'b0);
    // A trigger while the acknowledge is still high is refused
    wr(PSRC_ADDR_CAL, 8'hC0);
    `CHK(calReqQ, 1'b0)
    rd(PSRC_ADDR_CAL, {3'b110, trim});
    ana.calAck = 1'b0;
    repeat (5) @(posedge clk_sys);
    rd(PSRC_ADDR_CAL, {3'b100, trim});
    // Writing zero to start and junk to the trim field changes nothing
    wr(PSRC_ADDR_CAL, {3'b100, ~trim});
    repeat (4) @(posedge clk_sys);
    `CHK(calReqQ, 1'b0)
    rd(PSRC_ADDR_CAL, {3'b100, trim});
    // Clearing enable mid-run aborts the request and keeps the old trim
    wr(PSRC_ADDR_CAL, 8'hC0);
    waitReq(1'b1);
    wr(PSRC_ADDR_CAL, 8'h00);
    waitReq(1'b0);
    rd(PSRC_ADDR_CAL, {3'b000, trim});
    rd(8'h96, 8'h00);
    repeat (2) @(posedge clk_sys);
    $display("Test calibration done");
    summarize();
  end
endmodule

// ### src/psrc_top.sv
// Loop status reporting, mode control and reference oscillator trim calibration
// Summary of operation
// - Status bit 0 shows whether a valid master clock is detected.
// - Status bit 3 shows whether the loop has locked.
// - Status bit 4 shows whether loop or rate tracking is active.
// - Status bit 7 shows whether rate tracking has locked to word clock.
// - Status bits read 1 when active or valid, else 0; reset zero.
// - Calibration register bit 7 enables the calibration block; reset disabled.
// - The enable bit never gates the reference oscillator itself.
// - Oscillator runs when no valid master clock and not in standby.
// - Writing 1 to bit 6 with bit 7 also set starts a calibration when idle with the acknowledge low; writing 0 does nothing.
// - Trim result appears in read-only bits 4:0 after calibration; reset zero.
// - Mode field: 00 bypass, 01 normal, 10 rate tracking, 11 reserved.
`timescale 1ns/1ps

module psrc_top (
  input  wire logic                           clk_sys,
  input  wire logic                           rst,
  input  wire psrc_pkg::psrc_regreq_s         regReq,
  input  wire psrc_pkg::psrc_ana_s            ana,
  output logic [7:0]                          rdDataQ,
  output psrc_pkg::psrc_mode_e                loopModeQ,
  output logic                                refOscRunQ,
  output logic                                calReqQ
);
  import psrc_pkg::*;

  logic [PSRC_SYNC_W-1:0] syncIn;
  logic [PSRC_SYNC_W-1:0] sync1Q;
  logic [PSRC_SYNC_W-1:0] sync2Q;
  logic                   mclkS;
  logic                   lockS;
  logic                   trackS;
  logic                   standbyS;
  logic                   ackS;

  logic [7:0]             statusD;
  logic [7:0]             statusQ;
  psrc_mode_e             loopModeD;
  logic                   refOscRunD;
  logic                   calEnD;
  logic                   calEnQ;
  logic [PSRC_TRIM_W-1:0] trimD;
  logic [PSRC_TRIM_W-1:0] trimQ;
  psrc_cal_e              calStateD;
  psrc_cal_e              calStateQ;
  logic                   calReqD;
  logic [7:0]             rdDataD;
  logic                   wrCal;
  logic                   trigger;
  logic [1:0]             modeField;

  assign syncIn = {ana.mclkValid, ana.pllLock, ana.trackLock, ana.standby, ana.calAck};

  // Two-stage synchronisers; first stage feeds only the second
  for (genvar i = 0; i < PSRC_SYNC_W; i++) begin : gSync
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        sync1Q[i] <= 1'b0;
        sync2Q[i] <= 1'b0;
      end else begin
        sync1Q[i] <= syncIn[i];
        sync2Q[i] <= sync1Q[i];
      end
    end
  end

  assign {mclkS, lockS, trackS, standbyS, ackS} = sync2Q;

  // Status word; lock bits are masked by mode so a stale analog flag
  // from a previous mode cannot show through
  always_comb begin
    statusD                   = PSRC_STATUS_RST;
    statusD[PSRC_STAT_MCLK]   = mclkS;
    statusD[PSRC_STAT_LOCK]   = lockS && (loopModeQ != PSRC_MODE_BYPASS);
    statusD[PSRC_STAT_ACTIVE] = !standbyS && mclkS &&
                                ((loopModeQ == PSRC_MODE_NORMAL) ||
                                 (loopModeQ == PSRC_MODE_TRACK));
    statusD[PSRC_STAT_TRACK]  = trackS && (loopModeQ == PSRC_MODE_TRACK);
    // Oscillator follows clock presence and standby, enable bit plays no part
    refOscRunD = !mclkS && !standbyS;
  end

  // Register writes to control fields
  assign wrCal   = regReq.wrEn && (regReq.addr == PSRC_ADDR_CAL);
  assign trigger = wrCal && regReq.wrData[PSRC_CAL_START] && regReq.wrData[PSRC_CAL_EN];
  // Mode field of a write, kept apart so the checks can look back at it
  assign modeField = regReq.wrData[PSRC_MODE_MSB:PSRC_MODE_LSB];

  always_comb begin
    loopModeD = loopModeQ;
    calEnD    = calEnQ;
    if (regReq.wrEn && (regReq.addr == PSRC_ADDR_CTRL)) begin
      // Reserved code is refused so the loop never sees an undefined mode
      if (regReq.wrData[PSRC_MODE_MSB:PSRC_MODE_LSB] != PSRC_MODE_RSVD) begin
        loopModeD = psrc_mode_e'(regReq.wrData[PSRC_MODE_MSB:PSRC_MODE_LSB]);
      end
    end
    if (wrCal) begin
      calEnD = regReq.wrData[PSRC_CAL_EN];
    end
  end

  // Calibration handshake: request held until the analog side acknowledges or enable is cleared,
  // then released and the acknowledge must fall before a new run
  always_comb begin
    calStateD = calStateQ;
    calReqD   = calReqQ;
    trimD     = trimQ;
    case (calStateQ)
      PSRC_CAL_IDLE: begin
        if (trigger && !ackS) begin
          calStateD = PSRC_CAL_RUN;
          calReqD   = 1'b1;
        end
      end
      PSRC_CAL_RUN: begin
        if (!calEnD) begin
          calStateD = PSRC_CAL_RELEASE; // Disable aborts, trim kept
          calReqD   = 1'b0;
        end else if (ackS) begin
          trimD     = ana.calTrim;
          calStateD = PSRC_CAL_RELEASE;
          calReqD   = 1'b0;
        end
      end
      PSRC_CAL_RELEASE: begin
        if (!ackS) begin
          calStateD = PSRC_CAL_IDLE;
        end
      end
      default: begin
        calStateD = PSRC_CAL_IDLE;
        calReqD   = 1'b0;
      end
    endcase
  end

  // Read mux; bit 6 reads back as busy, bit 5 reserved
  always_comb begin
    rdDataD = rdDataQ;
    if (regReq.rdEn) begin
      case (regReq.addr)
        PSRC_ADDR_CTRL:   rdDataD = {loopModeQ, 6'h00};
        PSRC_ADDR_STATUS: rdDataD = statusQ;
        PSRC_ADDR_CAL:    rdDataD = {calEnQ, calStateQ != PSRC_CAL_IDLE, 1'b0, trimQ};
        default:          rdDataD = PSRC_RDATA_RST;
      endcase
    end
  end

  // State registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      statusQ    <= PSRC_STATUS_RST;
      loopModeQ  <= PSRC_MODE_RST;
      refOscRunQ <= 1'b0;
      calEnQ     <= PSRC_CAL_EN_RST;
      trimQ      <= PSRC_TRIM_RST;
      calStateQ  <= PSRC_CAL_IDLE;
      calReqQ    <= 1'b0;
      rdDataQ    <= PSRC_RDATA_RST;
    end else begin
      statusQ    <= statusD;
      loopModeQ  <= loopModeD;
      refOscRunQ <= refOscRunD;
      calEnQ     <= calEnD;
      trimQ      <= trimD;
      calStateQ  <= calStateD;
      calReqQ    <= calReqD;
      rdDataQ    <= rdDataD;
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence seqTrigger;
    (calStateQ == PSRC_CAL_IDLE) && trigger && !ackS;
  endsequence

  sequence seqAckSeen;
    (calStateQ == PSRC_CAL_RUN) && calEnQ && ackS && regReq.wrEn == 1'b0;
  endsequence

  sequence seqReqWaiting;
    calReqQ && !ackS && !(wrCal && !regReq.wrData[PSRC_CAL_EN]);
  endsequence

  AST_MCLK_FOLLOWS: assert property (
    1'b1 |-> ##3 (statusQ[PSRC_STAT_MCLK] == $past(ana.mclkValid, 3)))
    else $error("Master clock status does not follow detector");

  AST_LOCK_BYPASS: assert property (
    (loopModeQ == PSRC_MODE_BYPASS)[*2] |-> !statusQ[PSRC_STAT_LOCK])
    else $error("Lock shown in bypass mode");

  AST_ACTIVE_NEEDS_CLOCK: assert property (
    statusQ[PSRC_STAT_ACTIVE] |-> $past(mclkS) && !$past(standbyS))
    else $error("Active shown without clock or in standby");

  AST_TRACK_MODE: assert property (
    statusQ[PSRC_STAT_TRACK] |-> $past(loopModeQ) == PSRC_MODE_TRACK)
    else $error("Tracking lock shown outside tracking mode");

  AST_UNUSED_ZERO: assert property (
    statusQ[2:1] == 2'h0 && statusQ[6:5] == 2'h0)
    else $error("Unused status bits not zero");

  AST_REFOSC_RUN: assert property (
    1'b1 |=> refOscRunQ == (!$past(mclkS) && !$past(standbyS)))
    else $error("Reference oscillator run level wrong");

  AST_TRIGGER_DISABLED: assert property (
    (wrCal && !regReq.wrData[PSRC_CAL_EN] && calStateQ == PSRC_CAL_IDLE)
      |=> calStateQ == PSRC_CAL_IDLE && !calReqQ)
    else $error("Trigger acted while disabled");

  AST_TRIGGER_STARTS: assert property (
    seqTrigger |=> calReqQ && calStateQ == PSRC_CAL_RUN)
    else $error("Trigger did not raise calibration request");

  AST_TRIM_CAPTURE: assert property (
    seqAckSeen |=> trimQ == $past(ana.calTrim) && !calReqQ)
    else $error("Trim not captured on acknowledge");

  AST_TRIM_HOLD: assert property (
    (calStateQ != PSRC_CAL_RUN) |=> $stable(trimQ))
    else $error("Trim changed outside a calibration run");

  AST_MODE_RSVD: assert property (
    (regReq.wrEn && regReq.addr == PSRC_ADDR_CTRL &&
     regReq.wrData[PSRC_MODE_MSB:PSRC_MODE_LSB] == PSRC_MODE_RSVD) |=> $stable(loopModeQ))
    else $error("Reserved loop mode accepted");

  AST_DISABLE_ABORTS: assert property (
    (wrCal && !regReq.wrData[PSRC_CAL_EN]) |=> !calEnQ && !calReqQ)
    else $error("Clearing enable did not stop calibration");

  // Reading back: each register shows its current image the cycle after the strobe
  AST_STATUS_READ: assert property (
    (regReq.rdEn && regReq.addr == PSRC_ADDR_STATUS) |=> rdDataQ == $past(statusQ))
    else $error("Status read does not return the status image");

  AST_CAL_READ: assert property (
    (regReq.rdEn && regReq.addr == PSRC_ADDR_CAL) |=>
      rdDataQ[PSRC_TRIM_MSB:0] == $past(trimQ) && !rdDataQ[PSRC_TRIM_MSB+1] &&
      rdDataQ[PSRC_CAL_EN] == $past(calEnQ))
    else $error("Calibration read does not return trim and enable");

  AST_CTRL_READ: assert property (
    (regReq.rdEn && regReq.addr == PSRC_ADDR_CTRL) |=>
      rdDataQ[PSRC_MODE_MSB:PSRC_MODE_LSB] == $past(loopModeQ) &&
      rdDataQ[PSRC_MODE_LSB-1:0] == 6'h00)
    else $error("Mode read does not return the loop mode");

  AST_UNMAPPED_READ: assert property (
    (regReq.rdEn && regReq.addr != PSRC_ADDR_CTRL && regReq.addr != PSRC_ADDR_STATUS &&
     regReq.addr != PSRC_ADDR_CAL) |=> rdDataQ == PSRC_RDATA_RST)
    else $error("Unmapped read not zero");

  // Read data stands between reads so a slow master may pick it up late
  AST_RDATA_HOLD: assert property (
    !regReq.rdEn |=> $stable(rdDataQ))
    else $error("Read data changed without a read");

  AST_MODE_TAKEN: assert property (
    (regReq.wrEn && regReq.addr == PSRC_ADDR_CTRL && modeField != PSRC_MODE_RSVD)
      |=> loopModeQ == $past(modeField))
    else $error("Legal loop mode not taken");

  // Calibration handshake: enable, request standing, refusal while busy
  AST_ENABLE_SET: assert property (
    (wrCal && regReq.wrData[PSRC_CAL_EN]) |=> calEnQ)
    else $error("Setting enable did not enable calibration");

  AST_REQ_HOLD: assert property (
    seqReqWaiting |=> calReqQ)
    else $error("Calibration request dropped before acknowledge");

  AST_REQ_NEEDS_ENABLE: assert property (
    calReqQ |-> calEnQ)
    else $error("Calibration request while disabled");

  AST_RELEASE_QUIET: assert property (
    (calStateQ == PSRC_CAL_RELEASE) |=> !calReqQ)
    else $error("New request before acknowledge fell");

  // Status set direction: a live condition must show up one cycle later
  AST_OSC_STANDBY: assert property (
    standbyS |=> !refOscRunQ)
    else $error("Reference oscillator runs in standby");

  AST_TRACK_SHOWN: assert property (
    (trackS && loopModeQ == PSRC_MODE_TRACK) |=> statusQ[PSRC_STAT_TRACK])
    else $error("Tracking lock not shown");

  AST_LOCK_SHOWN: assert property (
    (lockS && loopModeQ != PSRC_MODE_BYPASS) |=> statusQ[PSRC_STAT_LOCK])
    else $error("Loop lock not shown");

  AST_ACTIVE_SHOWN: assert property (
    (mclkS && !standbyS &&
     (loopModeQ == PSRC_MODE_NORMAL || loopModeQ == PSRC_MODE_TRACK))
      |=> statusQ[PSRC_STAT_ACTIVE])
    else $error("Loop active not shown");

endmodule
